// ==== core/dcd_param_len.v ====
// Parameter byte count and supplementary flag for an opcode
`timescale 1ns/100ps
`include "dcd_regs.vh"
module dcd_param_len (
    input wire [7:0] opcode_i,
    output reg [6:0] count_o,
    output reg supp_o,
    output reg known_o
);
    // Lookup of parameter length
    always @* begin
        count_o = 7'h00;
        supp_o = 1'b0;
        known_o = 1'b1;
        case (opcode_i)
            `DCD_OP_NOP, `DCD_OP_SOFT_RESET, `DCD_OP_SLEEP_ENTER, `DCD_OP_SLEEP_EXIT,
            `DCD_OP_PARTIAL_ON, `DCD_OP_NORMAL_ON, `DCD_OP_INV_OFF, `DCD_OP_INV_ON,
            `DCD_OP_ALL_LIT, `DCD_OP_ALL_DARK, `DCD_OP_ALL_CANCEL,
            `DCD_OP_TEAR_OFF: count_o = 7'h00;
            `DCD_OP_READ_IDENT, `DCD_OP_READ_POWER, `DCD_OP_READ_MEMORY_ACCESS_CTRL_CMD,
            `DCD_OP_READ_PIXFMT, `DCD_OP_READ_IMAGE, `DCD_OP_READ_SIGNAL,
            `DCD_OP_COLUMN_WIN, `DCD_OP_ROW_WIN, `DCD_OP_PARTIAL_AREA,
            `DCD_OP_MEM_ACCESS, `DCD_OP_READ_LUM, `DCD_OP_READ_IDENT2: count_o = 7'h02;
            `DCD_OP_SCROLL_AREA: count_o = 7'h03;
            `DCD_OP_TEAR_ON, `DCD_OP_SCROLL_START, `DCD_OP_PIXEL_FMT,
            `DCD_OP_WRITE_LUM: count_o = 7'h01;
            `DCD_OP_MEM_WRITE, `DCD_OP_MEM_READ: count_o = 7'h7f;
            `DCD_OP_OTP_WRITE, `DCD_OP_OTP_READ: begin
                count_o = 7'h03;
                supp_o = 1'b1;
            end
            `DCD_OP_FUNC_SELECT, `DCD_OP_PRECHARGE_V, 8'hc8, 8'hc9, 8'hca, 8'hcd, 8'hce,
            8'hcf, 8'hd2, 8'hd3, 8'hd7: begin
                count_o = 7'h01;
                supp_o = 1'b1;
            end
            `DCD_OP_CMD_LOCK: count_o = 7'h01;
            `DCD_OP_LINEAR_GAMMA: supp_o = 1'b1;
            `DCD_OP_CONTRAST: begin
                count_o = 7'h05;
                supp_o = 1'b1;
            end
            `DCD_OP_GAMMA_TABLE: begin
                count_o = 7'h60;
                supp_o = 1'b1;
            end
            default: known_o = 1'b0;
        endcase
    end
endmodule

// ==== core/dcd_regs.vh ====
// Opcodes, status layout, reset values and soft-reset timing of the command decoder
`ifndef DCD_REGS_VH
`define DCD_REGS_VH
`define DCD_OP_NOP 8'h00
`define DCD_OP_SOFT_RESET 8'h01
`define DCD_OP_READ_IDENT 8'h04
`define DCD_OP_READ_POWER 8'h0a
`define DCD_OP_READ_MEMORY_ACCESS_CTRL_CMD 8'h0b
`define DCD_OP_READ_PIXFMT 8'h0c
`define DCD_OP_READ_IMAGE 8'h0d
`define DCD_OP_READ_SIGNAL 8'h0e
`define DCD_OP_SLEEP_ENTER 8'h10
`define DCD_OP_SLEEP_EXIT 8'h11
`define DCD_OP_PARTIAL_ON 8'h12
`define DCD_OP_NORMAL_ON 8'h13
`define DCD_OP_INV_OFF 8'h20
`define DCD_OP_INV_ON 8'h21
`define DCD_OP_ALL_LIT 8'h23
`define DCD_OP_ALL_DARK 8'h28
`define DCD_OP_ALL_CANCEL 8'h29
`define DCD_OP_COLUMN_WIN 8'h2a
`define DCD_OP_ROW_WIN 8'h2b
`define DCD_OP_MEM_WRITE 8'h2c
`define DCD_OP_MEM_READ 8'h2e
`define DCD_OP_PARTIAL_AREA 8'h30
`define DCD_OP_SCROLL_AREA 8'h33
`define DCD_OP_TEAR_OFF 8'h34
`define DCD_OP_TEAR_ON 8'h35
`define DCD_OP_MEM_ACCESS 8'h36
`define DCD_OP_SCROLL_START 8'h37
`define DCD_OP_PIXEL_FMT 8'h3a
`define DCD_OP_WRITE_LUM 8'h51
`define DCD_OP_READ_LUM 8'h52
`define DCD_OP_READ_IDENT2 8'hda
`define DCD_OP_OTP_WRITE 8'hb1
`define DCD_OP_OTP_READ 8'hb2
`define DCD_OP_FUNC_SELECT 8'hb3
`define DCD_OP_LINEAR_GAMMA 8'hb9
`define DCD_OP_CONTRAST 8'hba
`define DCD_OP_PRECHARGE_V 8'hbd
`define DCD_OP_GAMMA_TABLE 8'hbe
`define DCD_OP_CMD_LOCK 8'hfd
// Power status bit positions
`define DCD_PWR_PARTIAL 5
`define DCD_PWR_AWAKE 4
`define DCD_PWR_NORMAL 3
`define DCD_PWR_PIXELS 2
// Reset values
`define DCD_PWR_RESET 8'h08
`define DCD_IDENT_RESET 4'h0
`define DCD_MEMORY_ACCESS_CTRL_CMD_RESET 8'h00
`define DCD_PIXFMT_RESET 3'h6
`define DCD_TEAR_RESET 2'h0
// Timing: reset delay before decoding resumes
`define DCD_SWRST_NS 120
`define DCD_CLK_NS 40
`define DCD_SWRST_CYC ((`DCD_SWRST_NS + `DCD_CLK_NS - 1) / `DCD_CLK_NS)
`endif

// ==== core/dcd_sync.v ====
// Two-stage synchroniser for one pin
`timescale 1ns/100ps
module dcd_sync #(
    parameter [0:0] RESET_VAL = 1'b0
) (
    input wire clk_i,
    input wire reset_i,
    input wire d_i,
    output reg q_o
);
    reg meta_r;

    // Double flop, meta stage read only by the second
    // Reset to the pin's idle level so no false edge follows reset
    always @(posedge clk_i) begin
        if (reset_i) begin
            meta_r <= RESET_VAL;
            q_o <= RESET_VAL;
        end else begin
            meta_r <= d_i;
            q_o <= meta_r;
        end
    end
endmodule

// ==== core/dcd_top.v ====
// Command decoder of the display controller host port
// Operation
// - Opcode 00 changes nothing but ends memory write or read bursts.
// - Nop, soft reset, ident and power reads accepted in every mode.
// - Opcode 01 has no parameters and restores soft-reset defaults.
// - Soft reset switches the display output off.
// - Soft reset spares pixel-format read, memory access control, pixel format.
// - Of supplementary commands only one-time write state is restored.
// - Soft reset keeps memory and other supplementary settings.
// - Opcode 04 returns dummy, then ident nibble in bits 3..0.
// - Ident comes from one-time memory programming, zero before it.
// - Opcode 0a returns dummy, then power byte; bits 7,6,1,0 zero; resets 08h.
// - Power bit 5 set while partial mode active.
// - Power bit 4 zero asleep, one after sleep exit.
// - Power bit 3 set only without partial mode or scrolling.
// - Power bit 2 zero while all-dark in force, one after cancel.
// - Sleep, partial, normal, inversion, all-pixels, tear-off carry no parameters.
// - Column and row window commands take two parameters.
// - Scroll area takes three parameters, scroll start one.
// - Pixel format and tear-on commands take one parameter.
// - Gamma table collects 96 parameters; linear gamma none.
// - Colour contrast takes five parameters.
// - One-time write and read take three parameters each.
// - Status reads return a dummy byte first, status second.
`timescale 1ns/100ps
`include "dcd_regs.vh"
module dcd_top (
    input wire clk_i,
    input wire reset_i,
    input wire dc_sel_i,
    input wire wr_n_i,
    input wire rd_n_i,
    input wire [7:0] data_i,
    output reg [7:0] data_o,
    output reg data_oe_o,
    output reg display_on_o,
    output reg sleep_o,
    output reg partial_o,
    output reg scroll_o,
    output reg inverted_o,
    output reg all_lit_o,
    output reg all_dark_o,
    output reg mem_write_o,
    output reg mem_read_o,
    output reg param_valid_o,
    output reg [7:0] param_o,
    output reg [7:0] param_cmd_o,
    output reg [7:0] memory_access_ctrl_cmd_o,
    output reg [2:0] pixel_fmt_o,
    output reg [1:0] tear_o,
    output reg supp_unlocked_o,
    output reg [3:0] ident_nibble_o
);
    localparam ST_IDLE = 2'd0;
    localparam ST_PARAM = 2'd1;
    localparam ST_BURST = 2'd2;
    localparam ST_RESET = 2'd3;

    wire dc_s;
    wire wr_n_s;
    wire rd_n_s;
    wire [7:0] data_s;
    reg wr_n_d_r;
    reg rd_n_d_r;
    reg [1:0] state_r;
    reg [7:0] cmd_r;
    reg [6:0] left_r;
    reg [6:0] idx_r;
    reg [1:0] read_idx_r;
    reg [1:0] rst_cnt_r;
    reg lock_seen_r;
    reg otp_armed_r;
    reg [7:0] otp_par_r;

    // Pin synchronisers
    dcd_sync u_sync_dc (.clk_i(clk_i), .reset_i(reset_i), .d_i(dc_sel_i), .q_o(dc_s));
    // Strobes idle high, so their stages reset high
    dcd_sync #(.RESET_VAL(1'b1)) u_sync_wr (.clk_i(clk_i), .reset_i(reset_i), .d_i(wr_n_i),
        .q_o(wr_n_s));
    dcd_sync #(.RESET_VAL(1'b1)) u_sync_rd (.clk_i(clk_i), .reset_i(reset_i), .d_i(rd_n_i),
        .q_o(rd_n_s));
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_data
            dcd_sync u_sync_d (.clk_i(clk_i), .reset_i(reset_i), .d_i(data_i[g]),
                .q_o(data_s[g]));
        end
    endgenerate

    // Strobe edge detection on synchronised levels
    // write rising edge
    wire wr_rise = ~wr_n_d_r & wr_n_s;
    wire rd_fall = rd_n_d_r & ~rd_n_s;
    wire rd_rise = ~rd_n_d_r & rd_n_s;
    wire cmd_write = wr_rise & ~dc_s;
    wire par_write = wr_rise & dc_s;

    wire [6:0] len_w;
    wire supp_w;
    wire known_w;
    dcd_param_len u_len (.opcode_i(data_s), .count_o(len_w), .supp_o(supp_w),
        .known_o(known_w));

    // Supplementary opcodes need the unlock pair first
    // unlock gate
    // Function select right after lock is itself accepted, with its parameter
    wire accept_w = known_w & (~supp_w | supp_unlocked_o |
        (lock_seen_r & (data_s == `DCD_OP_FUNC_SELECT)));
    // Holdoff count cut to the counter width on purpose
    wire [31:0] swrst_cyc_w = `DCD_SWRST_CYC;

    // Power status byte assembled from live state
    // fixed zero bits
    wire [7:0] power_w;
    assign power_w[`DCD_PWR_PARTIAL] = partial_o;
    assign power_w[`DCD_PWR_AWAKE] = ~sleep_o;
    assign power_w[`DCD_PWR_NORMAL] = ~partial_o & ~scroll_o;
    // pixels-on bit
    // Clear from reset until the cancel opcode, clear again while all-dark
    assign power_w[`DCD_PWR_PIXELS] = display_on_o & ~all_dark_o;
    assign power_w[7:6] = 2'b00;
    assign power_w[1:0] = 2'b00;

    // Second read byte per status command
    reg [7:0] status_w;
    always @* begin
        case (cmd_r)
            `DCD_OP_READ_IDENT, `DCD_OP_READ_IDENT2: status_w = {4'h0, ident_nibble_o};
            `DCD_OP_READ_POWER: status_w = power_w;
            `DCD_OP_READ_MEMORY_ACCESS_CTRL_CMD: status_w = memory_access_ctrl_cmd_o & 8'he8;
            `DCD_OP_READ_PIXFMT: status_w = {5'h00, pixel_fmt_o};
            `DCD_OP_READ_IMAGE: status_w = {scroll_o, 1'b0, inverted_o, all_lit_o, 4'h0};
            `DCD_OP_READ_SIGNAL: status_w = {tear_o, 6'h00};
            default: status_w = 8'h00;
        endcase
    end

    // Read data path: dummy byte then status
    always @(posedge clk_i) begin
        if (reset_i) begin
            data_o <= 8'h00;
            data_oe_o <= 1'b0;
            read_idx_r <= 2'd0;
        end else begin
            if (cmd_write) begin
                read_idx_r <= 2'd0;
            end else if (rd_fall & dc_s) begin
                data_oe_o <= 1'b1;
                data_o <= (read_idx_r == 2'd1) ? status_w : 8'h00;
            end else if (rd_rise) begin
                data_oe_o <= 1'b0;
                if (read_idx_r != 2'd3) begin
                    read_idx_r <= read_idx_r + 2'd1;
                end
            end
        end
    end

    // Command sequencing and settings
    always @(posedge clk_i) begin
        if (reset_i) begin
            wr_n_d_r <= 1'b1;
            rd_n_d_r <= 1'b1;
            state_r <= ST_IDLE;
            cmd_r <= 8'h00;
            left_r <= 7'h00;
            idx_r <= 7'h00;
            rst_cnt_r <= 2'd0;
            display_on_o <= 1'b0;
            sleep_o <= 1'b1;
            partial_o <= 1'b0;
            scroll_o <= 1'b0;
            inverted_o <= 1'b0;
            all_lit_o <= 1'b0;
            all_dark_o <= 1'b0;
            mem_write_o <= 1'b0;
            mem_read_o <= 1'b0;
            param_valid_o <= 1'b0;
            param_o <= 8'h00;
            param_cmd_o <= 8'h00;
            memory_access_ctrl_cmd_o <= `DCD_MEMORY_ACCESS_CTRL_CMD_RESET;
            pixel_fmt_o <= `DCD_PIXFMT_RESET;
            tear_o <= `DCD_TEAR_RESET;
            supp_unlocked_o <= 1'b0;
            lock_seen_r <= 1'b0;
            otp_armed_r <= 1'b0;
            otp_par_r <= 8'h00;
            ident_nibble_o <= `DCD_IDENT_RESET;
        end else begin
            wr_n_d_r <= wr_n_s;
            rd_n_d_r <= rd_n_s;
            param_valid_o <= 1'b0;
            if (state_r == ST_RESET) begin
                // Hold off decoding briefly after soft reset
                if (rst_cnt_r == 2'd0) begin
                    state_r <= ST_IDLE;
                end else begin
                    rst_cnt_r <= rst_cnt_r - 2'd1;
                end
            end else if (cmd_write) begin
                mem_write_o <= 1'b0;
                mem_read_o <= 1'b0;
                cmd_r <= data_s;
                idx_r <= 7'h00;
                left_r <= accept_w ? len_w : 7'h00;
                state_r <= (accept_w && len_w != 7'h00) ? ST_PARAM : ST_IDLE;
                // Lock followed directly by function select
                lock_seen_r <= (data_s == `DCD_OP_CMD_LOCK);
                if (lock_seen_r && data_s == `DCD_OP_FUNC_SELECT) begin
                    supp_unlocked_o <= 1'b1;
                end
                if (accept_w) begin
                    case (data_s)
                        `DCD_OP_SOFT_RESET: begin
                            state_r <= ST_RESET;
                            rst_cnt_r <= swrst_cyc_w[1:0];
                            display_on_o <= 1'b0;
                            sleep_o <= 1'b1;
                            partial_o <= 1'b0;
                            scroll_o <= 1'b0;
                            inverted_o <= 1'b0;
                            all_lit_o <= 1'b0;
                            all_dark_o <= 1'b0;
                            tear_o <= `DCD_TEAR_RESET;
                            otp_armed_r <= 1'b0;
                            otp_par_r <= 8'h00;
                        end
                        `DCD_OP_SLEEP_ENTER: sleep_o <= 1'b1;
                        `DCD_OP_SLEEP_EXIT: sleep_o <= 1'b0;
                        `DCD_OP_PARTIAL_ON: partial_o <= 1'b1;
                        `DCD_OP_NORMAL_ON: begin
                            partial_o <= 1'b0;
                            scroll_o <= 1'b0;
                        end
                        `DCD_OP_INV_OFF: inverted_o <= 1'b0;
                        `DCD_OP_INV_ON: inverted_o <= 1'b1;
                        `DCD_OP_ALL_LIT: begin
                            all_lit_o <= 1'b1;
                            all_dark_o <= 1'b0;
                        end
                        `DCD_OP_ALL_DARK: begin
                            all_dark_o <= 1'b1;
                            all_lit_o <= 1'b0;
                        end
                        `DCD_OP_ALL_CANCEL: begin
                            all_dark_o <= 1'b0;
                            all_lit_o <= 1'b0;
                            display_on_o <= 1'b1;
                        end
                        `DCD_OP_TEAR_OFF: tear_o <= 2'b00;
                        `DCD_OP_MEM_WRITE: begin
                            mem_write_o <= 1'b1;
                            state_r <= ST_BURST;
                        end
                        `DCD_OP_MEM_READ: begin
                            mem_read_o <= 1'b1;
                            state_r <= ST_BURST;
                        end
                        default: ;
                    endcase
                end
            end else if (par_write && state_r != ST_IDLE) begin
                param_valid_o <= 1'b1;
                param_o <= data_s;
                param_cmd_o <= cmd_r;
                idx_r <= idx_r + 7'h01;
                if (state_r == ST_PARAM) begin
                    left_r <= left_r - 7'h01;
                    if (left_r == 7'h01) begin
                        state_r <= ST_IDLE;
                    end
                end
                case (cmd_r)
                    `DCD_OP_TEAR_ON: tear_o <= {1'b1, data_s[0]};
                    `DCD_OP_PIXEL_FMT: pixel_fmt_o <= data_s[2:0];
                    `DCD_OP_MEM_ACCESS: begin
                        if (idx_r == 7'h00) begin
                            memory_access_ctrl_cmd_o <= data_s;
                        end
                    end
                    `DCD_OP_SCROLL_START: scroll_o <= 1'b1;
                    `DCD_OP_CMD_LOCK: supp_unlocked_o <= 1'b0;
                    `DCD_OP_OTP_WRITE: begin
                        if (idx_r == 7'h00) begin
                            otp_par_r <= data_s;
                        end else if (idx_r == 7'h02) begin
                            otp_armed_r <= 1'b1;
                            ident_nibble_o <= otp_par_r[3:0];
                        end
                    end
                    default: ;
                endcase
            end
        end
    end
endmodule

// ==== tb/dcd_host_model.sv ====
// Host microcontroller model driving the parallel port pins
`timescale 1ns/100ps
module dcd_host_model (
    input wire clk_i,
    input wire [7:0] data_i,
    output logic dc_sel_o,
    output logic wr_n_o,
    output logic rd_n_o,
    output logic [7:0] data_o
);
    initial begin
        dc_sel_o = 1'b0;
        wr_n_o = 1'b1;
        rd_n_o = 1'b1;
        data_o = 8'h00;
    end
    task write_byte(input logic dc, input logic [7:0] val);
        @(negedge clk_i);
        dc_sel_o = dc;
        data_o = val;
        wr_n_o = 1'b0;
        repeat (6) @(negedge clk_i);
        wr_n_o = 1'b1;
        repeat (6) @(negedge clk_i);
        data_o = ~val; // Released bus no longer shows the byte
    endtask
    task read_byte(output logic [7:0] val);
        @(negedge clk_i);
        dc_sel_o = 1'b1;
        rd_n_o = 1'b0;
        repeat (6) @(negedge clk_i);
        val = data_i;
        rd_n_o = 1'b1;
        repeat (6) @(negedge clk_i);
    endtask
endmodule

// ==== tb/dcd_monitor.sv ====
// Port assertions for the command decoder
`timescale 1ns/100ps
module dcd_monitor (
    input wire clk_i,
    input wire reset_i,
    input wire dc_sel_i,
    input wire wr_n_i,
    input wire rd_n_i,
    input wire data_oe_o,
    input wire display_on_o,
    input wire sleep_o,
    input wire partial_o,
    input wire inverted_o,
    input wire mem_write_o,
    input wire mem_read_o,
    input wire param_valid_o,
    input wire [7:0] param_cmd_o,
    input wire [7:0] memory_access_ctrl_cmd_o,
    input wire [2:0] pixel_fmt_o
);
    default clocking mon_cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);
    // Bus driven after a long read strobe
    a_read_drives: assert property ((!rd_n_i && dc_sel_i) [*5] |-> data_oe_o)
        else $error("data bus not driven during read strobe");
    a_idle_released: assert property (rd_n_i [*8] |-> !data_oe_o)
        else $error("data bus driven without read strobe");
    a_param_pulse: assert property (param_valid_o |=> !param_valid_o)
        else $error("parameter pulse longer than one cycle");
    a_no_param_cmds: assert property (param_valid_o |-> !(param_cmd_o inside {8'h00, 8'h01,
        8'h10, 8'h11, 8'h12, 8'h13, 8'h20, 8'h21, 8'h23, 8'h28, 8'h29, 8'h34, 8'hb9}))
        else $error("parameter accepted for a command without parameters");
    a_burst_single: assert property (!(mem_write_o && mem_read_o))
        else $error("write and read bursts both open");
    a_reset_values: assert property ($fell(reset_i) |-> sleep_o && !display_on_o
        && !partial_o && !inverted_o && pixel_fmt_o == 3'h6)
        else $error("wrong values after reset");
    a_modes_held: assert property (wr_n_i [*8] |->
        $stable({sleep_o, partial_o, inverted_o, display_on_o}))
        else $error("mode changed without a write");
    a_format_held: assert property (wr_n_i [*8] |-> $stable({memory_access_ctrl_cmd_o, pixel_fmt_o}))
        else $error("format setting changed without a write");
endmodule
bind dcd_top dcd_monitor u_dcd_monitor (.clk_i(clk_i), .reset_i(reset_i), .dc_sel_i(dc_sel_i),
    .wr_n_i(wr_n_i), .rd_n_i(rd_n_i), .data_oe_o(data_oe_o), .display_on_o(display_on_o),
    .sleep_o(sleep_o), .partial_o(partial_o), .inverted_o(inverted_o),
    .mem_write_o(mem_write_o), .mem_read_o(mem_read_o), .param_valid_o(param_valid_o),
    .param_cmd_o(param_cmd_o), .memory_access_ctrl_cmd_o(memory_access_ctrl_cmd_o), .pixel_fmt_o(pixel_fmt_o));

// ==== tb/testbench.sv ====
// Self-checking testbench for the command decoder
`timescale 1ns/100ps
module testbench;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic dc_sel, wr_n, rd_n, oe, disp, slp, part, inv, mw, mr, pv;
    logic [7:0] din, dout, memory_access_ctrl_cmd, pulses, base, rd, par, pcmd;
    logic scr, lit, dark, unl;
    logic [1:0] tear;
    logic [2:0] pixfmt;
    logic [3:0] ident;
    logic p_part, p_awake, p_scroll, p_cancel;
    int miscompares = 0;
    int num_checks = 0;
    logic [7:0] ops [0:10] = '{8'h2a, 8'h2b, 8'h33, 8'h35, 8'h37, 8'h3a, 8'h36, 8'h10,
        8'h34, 8'h23, 8'h21};
    logic [7:0] cnt [0:10] = '{8'h02, 8'h02, 8'h03, 8'h01, 8'h01, 8'h01, 8'h02, 8'h00,
        8'h00, 8'h00, 8'h00};
    // Clock at 25 MHz
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    initial pulses = 8'h00;
    // Count accepted parameter bytes
    always @(posedge clk_i) begin
        if (pv === 1'b1) pulses <= pulses + 8'h01;
    end
    // Released bus shows the inverse of the last byte
    dcd_host_model u_dcd_host_model (.clk_i(clk_i), .data_i(oe === 1'b1 ? dout : ~dout),
        .dc_sel_o(dc_sel),
        .wr_n_o(wr_n), .rd_n_o(rd_n), .data_o(din));
    dcd_top u_dcd_top (.clk_i(clk_i), .reset_i(reset_i), .dc_sel_i(dc_sel), .wr_n_i(wr_n),
        .rd_n_i(rd_n), .data_i(din), .data_o(dout), .data_oe_o(oe), .display_on_o(disp),
        .sleep_o(slp), .partial_o(part), .scroll_o(scr), .inverted_o(inv), .all_lit_o(lit),
        .all_dark_o(dark), .mem_write_o(mw), .mem_read_o(mr), .param_valid_o(pv),
        .param_o(par), .param_cmd_o(pcmd), .memory_access_ctrl_cmd_o(memory_access_ctrl_cmd), .pixel_fmt_o(pixfmt),
        .tear_o(tear), .supp_unlocked_o(unl), .ident_nibble_o(ident));
    task check_byte(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t byte %h expected %h", $time, got, exp);
        end
    endtask
    task check_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    function logic [7:0] pwr();
        return {2'b00, p_part, p_awake, ~p_part & ~p_scroll, p_cancel, 2'b00};
    endfunction
    // Opcode then n parameter bytes of 05
    task cmd(input logic [7:0] op, input int n);
        base = pulses;
        u_dcd_host_model.write_byte(1'b0, op);
        repeat (n) u_dcd_host_model.write_byte(1'b1, 8'h05);
    endtask
    // Status read: dummy then status
    task rstat(input logic [7:0] op, input logic [7:0] exp);
        cmd(op, 0);
        u_dcd_host_model.read_byte(rd);
        check_byte(rd, 8'h00);
        u_dcd_host_model.read_byte(rd);
        check_byte(rd, exp);
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clk_i);
        miscompares++;
        conclude;
    end
    initial begin
        {p_part, p_awake, p_scroll, p_cancel} = 4'h0;
        repeat (16) @(negedge clk_i);
        reset_i = 1'b0;
        repeat (2) @(negedge clk_i);
        rstat(8'h0a, 8'h08);
        check_bit(oe, 1'b0);
        rstat(8'h04, 8'h00);
        $display("test reset done");
        for (int i = 0; i < 11; i++) begin
            cmd(ops[i], cnt[i] + 1);
            check_byte(pulses - base, cnt[i]);
        end
        p_scroll = 1'b1;
        check_byte(memory_access_ctrl_cmd, 8'h05);
        check_byte({5'h00, pixfmt}, 8'h05);
        check_bit(scr, 1'b1);
        check_bit(lit, 1'b1);
        check_byte({6'h00, tear}, 8'h00);
        check_bit(inv, 1'b1);
        $display("test counts done");
        rstat(8'h0a, pwr());
        cmd(8'h11, 0);
        p_awake = 1'b1;
        rstat(8'h0a, pwr());
        cmd(8'h12, 0);
        p_part = 1'b1;
        rstat(8'h0a, pwr());
        cmd(8'h13, 0);
        {p_part, p_scroll} = 2'b00;
        rstat(8'h0a, pwr());
        cmd(8'h29, 0);
        p_cancel = 1'b1;
        rstat(8'h0a, pwr());
        check_bit(disp, 1'b1);
        cmd(8'h28, 0);
        p_cancel = 1'b0;
        rstat(8'h0a, pwr());
        check_bit(dark, 1'b1);
        $display("test modes done");
        cmd(8'h2c, 3);
        check_bit(mw, 1'b1);
        cmd(8'h00, 0);
        check_bit(mw, 1'b0);
        cmd(8'h2e, 0);
        check_bit(mr, 1'b1);
        cmd(8'h00, 0);
        check_bit(mr, 1'b0);
        check_bit(inv, 1'b1);
        $display("test burst done");
        cmd(8'hba, 6);
        check_byte(pulses - base, 8'h00);
        cmd(8'hfd, 0);
        cmd(8'hb3, 1);
        check_byte(pulses - base, 8'h01);
        check_bit(unl, 1'b1);
        cmd(8'hba, 6);
        check_byte(pulses - base, 8'h05);
        cmd(8'hbe, 97);
        check_byte(pulses - base, 8'h60);
        cmd(8'hb9, 1);
        check_byte(pulses - base, 8'h00);
        cmd(8'hb2, 4);
        check_byte(pulses - base, 8'h03);
        cmd(8'hb1, 4);
        check_byte(pulses - base, 8'h03);
        check_byte(par, 8'h05);
        check_byte(pcmd, 8'hb1);
        rstat(8'h04, 8'h05);
        $display("test supplementary done");
        cmd(8'h35, 1);
        check_byte({6'h00, tear}, 8'h03);
        cmd(8'h12, 0);
        cmd(8'h01, 0);
        repeat (8) @(negedge clk_i);
        {p_part, p_awake, p_cancel} = 3'b000;
        check_bit(disp, 1'b0);
        check_bit(part, 1'b0);
        check_bit(slp, 1'b1);
        check_bit(inv, 1'b0);
        check_bit(dark, 1'b0);
        check_byte({6'h00, tear}, 8'h00);
        check_byte(memory_access_ctrl_cmd, 8'h05);
        check_byte({5'h00, pixfmt}, 8'h05);
        check_byte({4'h0, ident}, 8'h05);
        check_bit(unl, 1'b1);
        rstat(8'h0a, 8'h08);
        rstat(8'h04, 8'h05);
        $display("test soft reset done");
        conclude;
    end
endmodule
